// ==== logic/pmc_pkg.sv ====
package pmc_pkg;
    // array sizes
    localparam int PMC_N_DED   = 11;
    localparam int PMC_N_DMUX  = 10;
    localparam int PMC_N_MC    = 12;
    localparam int PMC_N_BUR   = 4;
    localparam int PMC_N_PAIR  = 6;
    localparam int PMC_GOE_IDX = 9;
    localparam int PMC_AW      = 4;
    localparam int PMC_DW      = 16;
    // synchroniser vector layout
    localparam int PMC_PIN_CLK1 = 0;
    localparam int PMC_PIN_CLK2 = 1;
    localparam int PMC_PIN_STCK = 2;
    localparam int PMC_PIN_DED  = 3;
    localparam int PMC_PIN_IO   = PMC_PIN_DED + PMC_N_DMUX;
    localparam int PMC_N_SYNC   = PMC_PIN_IO + PMC_N_MC;
    // register offsets
    localparam logic [PMC_AW-1:0] PMC_OFS_CTRL     = 4'h0;
    localparam logic [PMC_AW-1:0] PMC_OFS_DED_CSEL = 4'h1;
    localparam logic [PMC_AW-1:0] PMC_OFS_MC_CSEL  = 4'h2;
    localparam logic [PMC_AW-1:0] PMC_OFS_OE_SEL   = 4'h3;
    localparam logic [PMC_AW-1:0] PMC_OFS_FB_SEL   = 4'h4;
    localparam logic [PMC_AW-1:0] PMC_OFS_SH_SEL   = 4'h5;
    localparam logic [PMC_AW-1:0] PMC_OFS_ST_STAT  = 4'h6;
    localparam logic [PMC_AW-1:0] PMC_OFS_DED_STAT = 4'h7;
    localparam logic [PMC_AW-1:0] PMC_OFS_MCI_STAT = 4'h8;
    localparam logic [PMC_AW-1:0] PMC_OFS_BUR_STAT = 4'h9;
    // control field positions
    localparam int PMC_CTRL_CLK2_EN = 0;
    localparam int PMC_CTRL_GOE_EN  = 1;
    // reset values
    localparam logic [1:0]            PMC_RST_CTRL    = 2'h0;
    localparam logic [PMC_N_DMUX-1:0] PMC_RST_DED_SEL = 10'h000;
    localparam logic [PMC_N_MC-1:0]   PMC_RST_MC_SEL  = 12'h000;
    localparam logic [PMC_N_MC-1:0]   PMC_RST_OE_SEL  = 12'h000;
    localparam logic [PMC_N_MC-1:0]   PMC_RST_FB_SEL  = 12'h000;
    localparam logic [PMC_N_PAIR-1:0] PMC_RST_SH_SEL  = 6'h00;
    localparam logic                  PMC_RST_BIT     = 1'b0;
    localparam logic                  PMC_RST_PIN_OUT = 1'b1;

    function automatic logic pmc_rise(input logic prev, input logic cur);
        return cur & ~prev;
    endfunction

    // global reset wins over global set
    function automatic logic pmc_sr_bit(input logic rst, input logic set, input logic d);
        return rst ? 1'b0 : (set ? 1'b1 : d);
    endfunction

    function automatic logic [PMC_N_PAIR-1:0] pmc_pair_mux(input logic [PMC_N_MC-1:0]   in_q,
                                                          input logic [PMC_N_PAIR-1:0] odd);
        logic [PMC_N_PAIR-1:0] r;
        r = '0;
        for (int p = 0; p < PMC_N_PAIR; p++) begin
            r[p] = odd[p] ? in_q[2*p+1] : in_q[2*p];
        end
        return r;
    endfunction
endpackage

// ==== logic/pmc_inreg_bank.sv ====
module pmc_inreg_bank #(
    parameter int N = pmc_pkg::PMC_N_DED
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_ce,
    // clock edges and selection
    input  wire logic         i_cap1,
    input  wire logic         i_cap2,
    input  wire logic [N-1:0] i_sel,
    // data
    input  wire logic [N-1:0] i_d,
    output logic      [N-1:0] o_q
);
    import pmc_pkg::*;

    logic [N-1:0] q_r;
    logic [N-1:0] q_nxt;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_bit
            // each register loads only on the edge of its own selected clock
            assign q_nxt[g] = (i_sel[g] ? i_cap2 : i_cap1) ? i_d[g] : q_r[g];
        end
    endgenerate

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q_r <= {N{PMC_RST_BIT}};
        end else if (i_ce) begin
            q_r <= q_nxt;
        end
    end

    assign o_q = q_r;
endmodule

// ==== logic/pmc_macrocell.sv ====
module pmc_macrocell (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_ce,
    // clock edges
    input  wire logic i_st_cap,
    input  wire logic i_in_cap,
    // pin and array
    input  wire logic i_pin,
    input  wire logic i_pt_d,
    input  wire logic i_pt_oe,
    input  wire logic i_goe,
    input  wire logic i_gset,
    input  wire logic i_greset,
    // configuration
    input  wire logic i_oe_src,
    input  wire logic i_fb_src,
    // results
    output logic      o_state,
    output logic      o_inreg,
    output logic      o_fb,
    output logic      o_pin_out,
    output logic      o_pin_oe
);
    import pmc_pkg::*;

    logic st_r, st_nxt;
    logic in_r, in_nxt;
    logic fb_r, fb_nxt;
    logic out_r, out_nxt;
    logic oe_r, oe_nxt;

    always_comb begin
        st_nxt  = i_st_cap ? pmc_sr_bit(i_greset, i_gset, i_pt_d) : st_r;
        in_nxt  = i_in_cap ? i_pin : in_r;
        fb_nxt  = i_fb_src ? in_nxt : st_nxt;
        out_nxt = ~st_nxt;
        oe_nxt  = i_oe_src ? i_goe : i_pt_oe;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r  <= PMC_RST_BIT;
            in_r  <= PMC_RST_BIT;
            fb_r  <= PMC_RST_BIT;
            out_r <= PMC_RST_PIN_OUT;
            oe_r  <= PMC_RST_BIT;
        end else if (i_ce) begin
            st_r  <= st_nxt;
            in_r  <= in_nxt;
            fb_r  <= fb_nxt;
            out_r <= out_nxt;
            oe_r  <= oe_nxt;
        end
    end

    assign o_state   = st_r;
    assign o_inreg   = in_r;
    assign o_fb      = fb_r;
    assign o_pin_out = out_r;
    assign o_pin_oe  = oe_r;
endmodule

// ==== logic/pmc_top.sv ====
// The address map and strobed register access were decided locally.
module pmc_top (
    // clock, enable and reset
    input  wire logic                                i_clk,
    input  wire logic                                i_rst_n,
    input  wire logic                                i_ce,
    // register port
    input  wire logic [pmc_pkg::PMC_AW-1:0]          i_addr,
    input  wire logic [pmc_pkg::PMC_DW-1:0]          i_wdata,
    input  wire logic                                i_wr,
    input  wire logic                                i_rd,
    output logic      [pmc_pkg::PMC_DW-1:0]          o_rdata,
    // device pins
    input  wire logic                                i_clk1_pin,
    input  wire logic                                i_clk2_pin,
    input  wire logic                                i_state_clk_pin,
    input  wire logic [pmc_pkg::PMC_N_DMUX-1:0]      i_ded_pin,
    input  wire logic [pmc_pkg::PMC_N_MC-1:0]        i_io_pin,
    output logic      [pmc_pkg::PMC_N_MC-1:0]        o_io_out,
    output logic      [pmc_pkg::PMC_N_MC-1:0]        o_io_oe,
    // product-term array side
    input  wire logic [pmc_pkg::PMC_N_MC-1:0]        i_pt_d,
    input  wire logic [pmc_pkg::PMC_N_MC-1:0]        i_pt_oe,
    input  wire logic [pmc_pkg::PMC_N_BUR-1:0]       i_pt_bur_d,
    input  wire logic                                i_pt_set,
    input  wire logic                                i_pt_reset,
    output logic      [pmc_pkg::PMC_N_DED-1:0]       o_arr_ded,
    output logic      [pmc_pkg::PMC_N_MC-1:0]        o_arr_fb,
    output logic      [pmc_pkg::PMC_N_PAIR-1:0]      o_arr_shared,
    output logic      [pmc_pkg::PMC_N_BUR-1:0]       o_arr_bur
);
    import pmc_pkg::*;

    // reset release
    logic rst_m_r;
    logic rst_n_r;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_m_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_m_r <= 1'b1;
            rst_n_r <= rst_m_r;
        end
    end

    // pin synchronisers; only the second stage and the edge history are read
    logic [PMC_N_SYNC-1:0] pin_m_r, pin_m_nxt;
    logic [PMC_N_SYNC-1:0] pin_s_r;
    logic [2:0]            clk_d_r;

    always_comb begin
        pin_m_nxt = {i_io_pin, i_ded_pin, i_state_clk_pin, i_clk2_pin, i_clk1_pin};
    end

    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pin_m_r <= '0;
            pin_s_r <= '0;
            clk_d_r <= '0;
        end else if (i_ce) begin
            pin_m_r <= pin_m_nxt;
            pin_s_r <= pin_m_r;
            clk_d_r <= pin_s_r[2:0];
        end
    end

    // configuration registers
    logic [1:0]            ctrl_r, ctrl_nxt;
    logic [PMC_N_DMUX-1:0] ded_sel_r, ded_sel_nxt;
    logic [PMC_N_MC-1:0]   mc_sel_r, mc_sel_nxt;
    logic [PMC_N_MC-1:0]   oe_sel_r, oe_sel_nxt;
    logic [PMC_N_MC-1:0]   fb_sel_r, fb_sel_nxt;
    logic [PMC_N_PAIR-1:0] sh_sel_r, sh_sel_nxt;
    logic [PMC_DW-1:0]     rdata_r, rdata_nxt;

    // live state seen by the status reads
    logic [PMC_N_DED-1:0]  ded_q;
    logic [PMC_N_MC-1:0]   st_q;
    logic [PMC_N_MC-1:0]   mc_in_q;
    logic [PMC_N_BUR-1:0]  bur_r, bur_nxt;

    always_comb begin
        ctrl_nxt    = ctrl_r;
        ded_sel_nxt = ded_sel_r;
        mc_sel_nxt  = mc_sel_r;
        oe_sel_nxt  = oe_sel_r;
        fb_sel_nxt  = fb_sel_r;
        sh_sel_nxt  = sh_sel_r;
        rdata_nxt   = '0;
        // selections only move on a software write; nothing else touches them
        if (i_wr) begin
            case (i_addr)
                PMC_OFS_CTRL:     ctrl_nxt    = i_wdata[1:0];
                PMC_OFS_DED_CSEL: ded_sel_nxt = i_wdata[PMC_N_DMUX-1:0];
                PMC_OFS_MC_CSEL:  mc_sel_nxt  = i_wdata[PMC_N_MC-1:0];
                PMC_OFS_OE_SEL:   oe_sel_nxt  = i_wdata[PMC_N_MC-1:0];
                PMC_OFS_FB_SEL:   fb_sel_nxt  = i_wdata[PMC_N_MC-1:0];
                PMC_OFS_SH_SEL:   sh_sel_nxt  = i_wdata[PMC_N_PAIR-1:0];
                default: begin
                end
            endcase
        end
        if (i_rd) begin
            case (i_addr)
                PMC_OFS_CTRL:     rdata_nxt = {14'h0000, ctrl_r};
                PMC_OFS_DED_CSEL: rdata_nxt = {6'h00, ded_sel_r};
                PMC_OFS_MC_CSEL:  rdata_nxt = {4'h0, mc_sel_r};
                PMC_OFS_OE_SEL:   rdata_nxt = {4'h0, oe_sel_r};
                PMC_OFS_FB_SEL:   rdata_nxt = {4'h0, fb_sel_r};
                PMC_OFS_SH_SEL:   rdata_nxt = {10'h000, sh_sel_r};
                PMC_OFS_ST_STAT:  rdata_nxt = {4'h0, st_q};
                PMC_OFS_DED_STAT: rdata_nxt = {5'h00, ded_q};
                PMC_OFS_MCI_STAT: rdata_nxt = {4'h0, mc_in_q};
                PMC_OFS_BUR_STAT: rdata_nxt = {12'h000, bur_r};
                default:          rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ctrl_r    <= PMC_RST_CTRL;
            ded_sel_r <= PMC_RST_DED_SEL;
            mc_sel_r  <= PMC_RST_MC_SEL;
            oe_sel_r  <= PMC_RST_OE_SEL;
            fb_sel_r  <= PMC_RST_FB_SEL;
            sh_sel_r  <= PMC_RST_SH_SEL;
            rdata_r   <= '0;
        end else if (i_ce) begin
            ctrl_r    <= ctrl_nxt;
            ded_sel_r <= ded_sel_nxt;
            mc_sel_r  <= mc_sel_nxt;
            oe_sel_r  <= oe_sel_nxt;
            fb_sel_r  <= fb_sel_nxt;
            sh_sel_r  <= sh_sel_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

    // clock edges and effective selections
    logic                  clk2_en;
    logic                  goe_en;
    logic                  goe;
    logic                  clk1_rise;
    logic                  clk2_rise;
    logic                  st_rise;
    logic [PMC_N_DED-1:0]  ded_s;
    logic [PMC_N_DED-1:0]  ded_sel_eff;
    logic [PMC_N_MC-1:0]   mc_sel_eff;
    logic [PMC_N_MC-1:0]   mc_cap;
    logic [PMC_N_MC-1:0]   io_s;

    always_comb begin
        clk2_en   = ctrl_r[PMC_CTRL_CLK2_EN];
        goe_en    = ctrl_r[PMC_CTRL_GOE_EN];
        clk1_rise = pmc_rise(clk_d_r[PMC_PIN_CLK1], pin_s_r[PMC_PIN_CLK1]);
        // with the enable clear the second clock pin never clocks anything
        clk2_rise = clk2_en & pmc_rise(clk_d_r[PMC_PIN_CLK2], pin_s_r[PMC_PIN_CLK2]);
        st_rise   = pmc_rise(clk_d_r[PMC_PIN_STCK], pin_s_r[PMC_PIN_STCK]);
        // the second clock pin doubles as the last dedicated data input
        ded_s     = {pin_s_r[PMC_PIN_CLK2], pin_s_r[PMC_PIN_IO-1:PMC_PIN_DED]};
        io_s      = pin_s_r[PMC_N_SYNC-1:PMC_PIN_IO];
        // the register on the second clock pin has no clock mux: it always takes clock one
        ded_sel_eff = {1'b0, ded_sel_r & {PMC_N_DMUX{clk2_en}}};
        mc_sel_eff  = mc_sel_r & {PMC_N_MC{clk2_en}};
        mc_cap      = (mc_sel_eff & {PMC_N_MC{clk2_rise}})
                    | (~mc_sel_eff & {PMC_N_MC{clk1_rise}});
        // sampled, so the enable lags the pin by the synchroniser delay
        goe         = goe_en & ded_s[PMC_GOE_IDX];
    end

    // dedicated input registers
    pmc_inreg_bank #(
        .N (PMC_N_DED)
    ) u_ded (
        .i_clk   (i_clk),
        .i_rst_n (rst_n_r),
        .i_ce    (i_ce),
        .i_cap1  (clk1_rise),
        .i_cap2  (clk2_rise),
        .i_sel   (ded_sel_eff),
        .i_d     (ded_s),
        .o_q     (ded_q)
    );

    // I/O macrocells
    genvar m;
    generate
        for (m = 0; m < PMC_N_MC; m++) begin : g_mc
            pmc_macrocell u_mc (
                .i_clk     (i_clk),
                .i_rst_n   (rst_n_r),
                .i_ce      (i_ce),
                .i_st_cap  (st_rise),
                .i_in_cap  (mc_cap[m]),
                .i_pin     (io_s[m]),
                .i_pt_d    (i_pt_d[m]),
                .i_pt_oe   (i_pt_oe[m]),
                .i_goe     (goe),
                .i_gset    (i_pt_set),
                .i_greset  (i_pt_reset),
                .i_oe_src  (oe_sel_r[m]),
                .i_fb_src  (fb_sel_r[m]),
                .o_state   (st_q[m]),
                .o_inreg   (mc_in_q[m]),
                .o_fb      (o_arr_fb[m]),
                .o_pin_out (o_io_out[m]),
                .o_pin_oe  (o_io_oe[m])
            );
        end
    endgenerate

    // buried registers and the array-facing copies
    logic [PMC_N_DED-1:0]  arr_ded_r, arr_ded_nxt;
    logic [PMC_N_PAIR-1:0] arr_sh_r, arr_sh_nxt;
    logic [PMC_N_DED-1:0]  ded_mask;

    always_comb begin
        // a reset term from a registered input comes an input edge late, then acts here
        for (int b = 0; b < PMC_N_BUR; b++) begin
            bur_nxt[b] = st_rise ? pmc_sr_bit(i_pt_reset, i_pt_set, i_pt_bur_d[b])
                                 : bur_r[b];
        end
        ded_mask              = '1;
        // a pin serving as global enable offers no data to the array
        ded_mask[PMC_GOE_IDX] = ~goe_en;
        arr_ded_nxt           = ded_q & ded_mask;
        arr_sh_nxt            = pmc_pair_mux(mc_in_q, sh_sel_r);
    end

    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            bur_r     <= {PMC_N_BUR{PMC_RST_BIT}};
            arr_ded_r <= {PMC_N_DED{PMC_RST_BIT}};
            arr_sh_r  <= {PMC_N_PAIR{PMC_RST_BIT}};
        end else if (i_ce) begin
            bur_r     <= bur_nxt;
            arr_ded_r <= arr_ded_nxt;
            arr_sh_r  <= arr_sh_nxt;
        end
    end

    assign o_rdata      = rdata_r;
    assign o_arr_ded    = arr_ded_r;
    assign o_arr_shared = arr_sh_r;
    assign o_arr_bur    = bur_r;

    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n_r);

    sequence s_reset_req;
        i_ce && st_rise && i_pt_reset;
    endsequence

    sequence s_set_req;
        i_ce && st_rise && i_pt_set && !i_pt_reset;
    endsequence

    sequence s_all_cleared;
        (st_q == '0) && (bur_r == '0) && (o_io_out == '1);
    endsequence

    a_reset_all_regs: assert property (s_reset_req |=> s_all_cleared)
        else $error("global reset did not clear all state and buried registers");

    a_set_all_regs: assert property (s_set_req |=> (st_q == '1) && (bur_r == '1))
        else $error("global set did not set all state and buried registers");

    a_pin_inverted: assert property (o_io_out == ~st_q)
        else $error("output pin is not the inverse of its state register");

    a_oe_source_mux: assert property (i_ce |=> o_io_oe == (($past(oe_sel_r)
        & {PMC_N_MC{$past(goe)}}) | (~$past(oe_sel_r) & $past(i_pt_oe))))
        else $error("output enable does not follow its selected source");

    a_fb_mux_route: assert property ($stable(fb_sel_r) |->
        o_arr_fb == ((fb_sel_r & mc_in_q) | (~fb_sel_r & st_q)))
        else $error("feedback mux routes the wrong register");

    a_shared_mux_pick: assert property (i_ce |=>
        o_arr_shared == pmc_pair_mux($past(mc_in_q), $past(sh_sel_r)))
        else $error("shared input mux picks the wrong pin of its pair");

    a_ded_clk1_load: assert property (i_ce && clk1_rise && !ded_sel_eff[0]
        |=> ded_q[0] == $past(ded_s[0]))
        else $error("dedicated register missed its clock one edge");

    a_ded_clk2_load: assert property (i_ce && clk2_rise && ded_sel_eff[0]
        |=> ded_q[0] == $past(ded_s[0]))
        else $error("dedicated register missed its clock two edge");

    a_clk2_gate_off: assert property (!clk2_en |-> (ded_sel_eff == '0) && !clk2_rise)
        else $error("second clock active while its enable is clear");

    a_ded_hold_data: assert property (i_ce && !clk1_rise && !clk2_rise
        |=> $stable(ded_q) ##1 $stable(o_arr_ded) || !$past(i_ce))
        else $error("dedicated register changed without a clock edge");

    a_goe_masks_data: assert property (goe_en && i_ce |=> !o_arr_ded[PMC_GOE_IDX])
        else $error("global enable pin still feeds data to the array");

    a_cfg_held_static: assert property (!i_wr |=> $stable(oe_sel_r) && $stable(fb_sel_r)
        && $stable(sh_sel_r) && $stable(mc_sel_r) && $stable(ded_sel_r))
        else $error("configuration changed without a write");

    a_rd_data_once: assert property (!i_rd && i_ce |=> o_rdata == '0)
        else $error("read data present outside the read answer cycle");

    // input captures follow their selected clock; state moves only on its own edge
    a_mc_in_load: assert property (i_ce && mc_cap[0] |=> mc_in_q[0] == $past(io_s[0]))
        else $error("macrocell input register missed its clock edge");

    a_mc_clk1_default: assert property (i_ce && clk1_rise && !mc_sel_r[0]
        |=> mc_in_q[0] == $past(io_s[0]))
        else $error("macrocell input register ignores clock one by default");

    a_oe_global_pin: assert property (i_ce && goe_en && oe_sel_r[0]
        |=> o_io_oe[0] == $past(ded_s[PMC_GOE_IDX]))
        else $error("output enable does not follow the global enable pin");

    a_state_sync_only: assert property (i_ce && !st_rise
        |=> $stable(st_q) && $stable(bur_r))
        else $error("state or buried register moved without a state clock edge");
endmodule

// ==== dv/pmc_board.sv ====
module pmc_board (
    // clock
    input  wire logic                           i_clk,
    // pins toward the device
    output logic      [2:0]                     o_clk_pins,
    output logic      [pmc_pkg::PMC_N_DMUX-1:0] o_ded,
    output logic      [pmc_pkg::PMC_N_MC-1:0]   o_io
);
    timeunit 1ns;
    timeprecision 1ps;
    import pmc_pkg::*;

    // clock pins stand still low between pulses
    initial begin
        o_clk_pins = 3'h0;
        o_ded      = '0;
        o_io       = '0;
    end

    // high and low phases longer than the two-flop synchroniser needs
    task automatic pulse(input int k);
        @(posedge i_clk) o_clk_pins[k] <= 1'b1;
        repeat (3) @(posedge i_clk);
        o_clk_pins[k] <= 1'b0;
        repeat (5) @(posedge i_clk);
    endtask

    task automatic set_ded(input logic [PMC_N_DMUX-1:0] v);
        @(posedge i_clk) o_ded <= v;
    endtask

    // second clock pin used as plain data while it is not a clock
    task automatic set_lvl2(input logic v);
        @(posedge i_clk) o_clk_pins[1] <= v;
    endtask

    // io data is only offered while the device keeps its buffers off
    task automatic set_io(input logic [PMC_N_MC-1:0] v);
        @(posedge i_clk) o_io <= v;
    endtask
endmodule

// ==== dv/test_pmc_top.sv ====
module test_pmc_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pmc_pkg::*;

    logic                  i_clk, i_rst_n, i_ce, i_wr, i_rd, i_pt_set, i_pt_reset, rst_from_ded;
    logic [PMC_AW-1:0]     i_addr;
    logic [PMC_DW-1:0]     i_wdata, o_rdata;
    logic [2:0]            clk_pins;
    logic [PMC_N_DMUX-1:0] ded;
    logic [PMC_N_MC-1:0]   io_drv, io_wire, o_io_out, o_io_oe, i_pt_d, i_pt_oe, o_arr_fb;
    logic [PMC_N_DED-1:0]  o_arr_ded;
    logic [PMC_N_PAIR-1:0] o_arr_shared, sh_exp, sh_sel;
    logic [PMC_N_BUR-1:0]  i_pt_bur_d, o_arr_bur;
    logic [PMC_N_MC-1:0]   oe_tab [3];
    int                    fail_count, checks;

    // pin level resolved from both drivers
    assign io_wire = (o_io_oe & o_io_out) | (~o_io_oe & io_drv);

    pmc_board pmc_board_inst (.i_clk(i_clk), .o_clk_pins(clk_pins), .o_ded(ded), .o_io(io_drv));

    pmc_top pmc_top_inst (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_clk1_pin(clk_pins[0]), .i_clk2_pin(clk_pins[1]), .i_state_clk_pin(clk_pins[2]),
        .i_ded_pin(ded), .i_io_pin(io_wire), .o_io_out(o_io_out), .o_io_oe(o_io_oe),
        .i_pt_d(i_pt_d), .i_pt_oe(i_pt_oe), .i_pt_bur_d(i_pt_bur_d), .i_pt_set(i_pt_set),
        .i_pt_reset(rst_from_ded ? o_arr_ded[0] : i_pt_reset),
        .o_arr_ded(o_arr_ded), .o_arr_fb(o_arr_fb), .o_arr_shared(o_arr_shared),
        .o_arr_bur(o_arr_bur)
    );

    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    task automatic end_of_test();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [PMC_AW-1:0] a, input logic [15:0] d);
        @(posedge i_clk) begin
            i_addr  <= a;
            i_wdata <= d;
            i_wr    <= 1'b1;
        end
        @(posedge i_clk) i_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [PMC_AW-1:0] a, input logic [15:0] e);
        @(posedge i_clk) begin
            i_addr <= a;
            i_rd   <= 1'b1;
        end
        @(posedge i_clk) i_rd <= 1'b0;
        #1;
        chk(o_rdata, e);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    // array-side terms change right after an edge, like the rest of the stimulus
    task automatic pt(input logic [PMC_N_MC-1:0] d, input logic [PMC_N_BUR-1:0] b,
                      input logic [1:0] sr);
        @(posedge i_clk) begin
            i_pt_d                 <= d;
            i_pt_bur_d             <= b;
            {i_pt_set, i_pt_reset} <= sr;
        end
    endtask

    // sized well above the whole sequence, which takes a few hundred cycles
    initial begin
        #100000;
        fail_count++;
        end_of_test();
    end

    initial begin
        {i_rst_n, i_ce, i_wr, i_rd, rst_from_ded} = 5'h08;
        {i_addr, i_wdata, i_pt_oe} = '0;
        oe_tab = '{12'h000, 12'hFFF, 12'hA5C};
        pt(12'h000, 4'h0, 2'b00);
        repeat (7) @(posedge i_clk);
        i_rst_n <= 1'b1;
        idle(3);
        chk(16'(o_io_out), 16'h0FFF);
        chk(16'(o_io_oe), 16'h0000);
        for (int a = 0; a < 16; a++) rd(PMC_AW'(a), 16'h0000);
        pmc_board_inst.set_ded(10'h2A5);
        idle(6);
        chk(16'(o_arr_ded), 16'h0000);
        pmc_board_inst.pulse(0);
        chk(16'(o_arr_ded), 16'h02A5);
        @(posedge i_clk) i_ce <= 1'b0;
        wr(PMC_OFS_CTRL, 16'h0003);
        @(posedge i_clk) i_ce <= 1'b1;
        rd(PMC_OFS_CTRL, 16'h0000);
        // clock two stays data while disabled, even with selections set
        wr(PMC_OFS_DED_CSEL, 16'h03FF);
        pmc_board_inst.set_lvl2(1'b1);
        pmc_board_inst.set_ded(10'h15A);
        pmc_board_inst.pulse(0);
        chk(16'(o_arr_ded), 16'h055A);
        pmc_board_inst.set_lvl2(1'b0);
        wr(PMC_OFS_CTRL, 16'h0001);
        wr(PMC_OFS_DED_CSEL, 16'h000F);
        rd(PMC_OFS_DED_CSEL, 16'h000F);
        pmc_board_inst.set_ded(10'h0F0);
        pmc_board_inst.pulse(0);
        chk(16'(o_arr_ded), 16'h00FA);
        pmc_board_inst.pulse(1);
        chk(16'(o_arr_ded), 16'h00F0);
        wr(PMC_OFS_CTRL, 16'h0002);
        wr(PMC_OFS_OE_SEL, 16'h0FFF);
        pmc_board_inst.set_ded(10'h200);
        idle(6);
        chk(16'(o_io_oe), 16'h0FFF);
        pmc_board_inst.pulse(0);
        chk(16'(o_arr_ded), 16'h0000);
        wr(PMC_OFS_OE_SEL, 16'h00F0);
        for (int i = 0; i < 3; i++) begin
            @(posedge i_clk) i_pt_oe <= oe_tab[i];
            idle(4);
            chk(16'(o_io_oe), 16'(12'h0F0 | (oe_tab[i] & 12'hF0F)));
        end
        pmc_board_inst.set_ded(10'h000);
        idle(6);
        chk(16'(o_io_oe), 16'(oe_tab[2] & 12'hF0F));
        wr(PMC_OFS_OE_SEL, 16'h0000);
        @(posedge i_clk) i_pt_oe <= oe_tab[0];
        pt(12'h0F3, 4'hA, 2'b00);
        pmc_board_inst.pulse(2);
        chk(16'(o_io_out), 16'h0F0C);
        chk(16'(o_arr_fb), 16'h00F3);
        chk(16'(o_arr_bur), 16'h000A);
        rd(PMC_OFS_ST_STAT, 16'h00F3);
        pt(12'h0F3, 4'hA, 2'b10);
        pmc_board_inst.pulse(2);
        chk(16'(o_io_out), 16'h0000);
        chk(16'(o_arr_bur), 16'h000F);
        pt(12'h0F3, 4'hA, 2'b11);
        pmc_board_inst.pulse(2);
        chk(16'(o_io_out), 16'h0FFF);
        chk(16'(o_arr_bur), 16'h0000);
        rd(PMC_OFS_ST_STAT, 16'h0000);
        pt(12'h0F3, 4'hA, 2'b00);
        pmc_board_inst.set_io(12'h9C6);
        pmc_board_inst.pulse(0);
        rd(PMC_OFS_MCI_STAT, 16'h09C6);
        chk(16'(o_arr_fb), 16'h0000);
        wr(PMC_OFS_FB_SEL, 16'h0FFF);
        idle(2);
        chk(16'(o_arr_fb), 16'h09C6);
        for (int s = 0; s < 3; s++) begin
            sh_sel = (s == 0) ? 6'h00 : ((s == 1) ? 6'h3F : 6'h15);
            for (int p = 0; p < PMC_N_PAIR; p++) sh_exp[p] = 1'(12'h9C6 >> (2*p + int'(sh_sel[p])));
            wr(PMC_OFS_SH_SEL, 16'(sh_sel));
            idle(3);
            chk(16'(o_arr_shared), 16'(sh_exp));
        end
        // macrocell input registers move to clock two only while it is enabled
        wr(PMC_OFS_CTRL, 16'h0001);
        wr(PMC_OFS_MC_CSEL, 16'h0FFF);
        pmc_board_inst.set_io(12'h35A);
        pmc_board_inst.pulse(0);
        rd(PMC_OFS_MCI_STAT, 16'h09C6);
        pmc_board_inst.pulse(1);
        rd(PMC_OFS_MCI_STAT, 16'h035A);
        wr(PMC_OFS_CTRL, 16'h0000);
        // set/reset coming from a registered input needs two clocks
        wr(PMC_OFS_FB_SEL, 16'h0000);
        pt(12'h0FF, 4'h5, 2'b00);
        pmc_board_inst.pulse(2);
        chk(16'(o_arr_bur), 16'h0005);
        rst_from_ded <= 1'b1;
        pmc_board_inst.set_ded(10'h001);
        pmc_board_inst.pulse(2);
        rd(PMC_OFS_ST_STAT, 16'h00FF);
        pmc_board_inst.pulse(0);
        pmc_board_inst.pulse(2);
        rd(PMC_OFS_ST_STAT, 16'h0000);
        chk(16'(o_arr_bur), 16'h0000);
        end_of_test();
    end
endmodule
